// ---- hdl/tcl_loader.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "tcl_cfg.svh"
module tcl_loader
  import tcl_pkg::*;
#(
  parameter int W = `TCL_CFG_WIDTH,
  parameter int SETTLE_CYC = `TCL_SETTLE_CYC
) (
  input wire logic CORE_CLK,
  input wire logic RST_N,
  input wire logic SUPPLY_OK,
  input wire logic STROBE,
  input wire logic TX_ACTIVATE,
  input wire logic POWER_UP_REQUEST,
  input wire logic CONFIG_SHIFT_CLOCK,
  input wire logic CONFIG_DATA,
  input wire logic TX_DONE,
  output logic [W-1:0] CONFIG_WORD,
  output logic CONFIG_VALID,
  output logic CRC_ENABLE,
  output logic CRC_LEN16,
  output logic BURST_MODE,
  output logic RATE_1M,
  output logic [2:0] CRYSTAL_FREQ_SELECT,
  output logic [1:0] OUTPUT_POWER_LEVEL,
  output logic [6:0] CHANNEL_NUMBER,
  output logic CONFIG_MODE,
  output logic ACTIVE_MODE,
  output logic TX_START,
  output logic STANDBY,
  output logic SEQ_ERROR
);
  localparam int CW = $clog2(W+1);
  localparam int TW = $clog2(SETTLE_CYC+1);
  localparam logic [W-1:0] DEFAULT = `TCL_CFG_DEFAULT;

  // elaboration refuses widths and counts the logic cannot serve
  if (W != `TCL_CFG_WIDTH) begin : g_bad_width
    $error("loader needs an 18-bit word");
  end
  if (SETTLE_CYC < 1) begin : g_bad_settle
    $error("settle count must be positive");
  end

  function automatic logic [W-1:0] low_mask(input logic [CW-1:0] n);
    logic [W-1:0] m;
    m = '0;
    for (int i = 0; i < W; i++) begin
      if (i < int'(n)) m[i] = 1'b1;
    end
    return m;
  endfunction

  logic [2:0] pins;
  logic strobe_s;
  logic act_s;
  logic sclk_s;
  tcl_sync #(.W(3)) u_sync (
    .clk(CORE_CLK),
    .rst_n(RST_N),
    .d({STROBE, TX_ACTIVATE, CONFIG_SHIFT_CLOCK}),
    .q(pins)
  );
  assign strobe_s = pins[2];
  assign act_s = pins[1];
  assign sclk_s = pins[0];

  logic data_s;
  tcl_sync #(.W(1)) u_sync_d (
    .clk(CORE_CLK),
    .rst_n(RST_N),
    .d(CONFIG_DATA),
    .q(data_s)
  );

  logic [1:0] lvl_sup;
  tcl_sync #(.W(2)) u_sync_l (
    .clk(CORE_CLK),
    .rst_n(RST_N),
    .d({SUPPLY_OK, POWER_UP_REQUEST}),
    .q(lvl_sup)
  );

  logic sclk_d;
  logic strobe_d;
  logic act_d;
  logic [1:0] done_p;
  logic shift_rise;
  logic strobe_fall;
  logic act_fall;

  // data waits one extra stage so it aligns past the shift clock edge detect
  logic data_d;
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      sclk_d <= 1'b0;
      strobe_d <= 1'b0;
      act_d <= 1'b0;
      data_d <= 1'b0;
      done_p <= '0;
    end else begin
      sclk_d <= sclk_s;
      strobe_d <= strobe_s;
      act_d <= act_s;
      data_d <= data_s;
      done_p <= {done_p[0], TX_DONE};
    end
  end
  // edges come from synchronised copies only, never from the raw pins
  assign shift_rise = sclk_s & ~sclk_d;
  assign strobe_fall = strobe_d & ~strobe_s;
  assign act_fall = act_d & ~act_s;

  logic [W-1:0] shreg;
  logic [CW-1:0] count;
  // both stages high, so a one-cycle strobe glitch never shifts
  // [RULE24] shifter only runs in strobe window
  tcl_shifter #(.W(W)) u_shift (
    .clk(CORE_CLK),
    .rst_n(RST_N),
    .strobe(strobe_s & strobe_d),
    .shift_rise(shift_rise),
    .data(data_d),
    .shreg(shreg),
    .count(count)
  );

  tcl_state_t state;
  tcl_state_t next_state;
  logic [TW-1:0] settle;
  logic [TW-1:0] next_settle;
  logic [W-1:0] cfg;
  logic [W-1:0] next_cfg;
  logic valid;
  logic next_valid;
  logic tx_start;
  logic next_tx_start;
  logic seq_err;
  logic next_seq_err;
  logic supply;
  logic power_up_request;
  logic [W-1:0] mask;

  assign supply = lvl_sup[1];
  assign power_up_request = lvl_sup[0];
  // mask covers only the bits shifted in during this access
  assign mask = low_mask(count);

  always_comb begin
    next_state = state;
    next_settle = settle;
    next_cfg = cfg;
    next_valid = valid;
    next_tx_start = 1'b0;
    next_seq_err = seq_err;
    if (!supply) begin
      // [RULE18] supply loss drops the word
      next_state = TCL_OFF;
      next_cfg = DEFAULT;
      next_valid = 1'b0;
      next_settle = '0;
    end else begin
      // [RULE20] both high is flagged, sticky
      if (strobe_s && act_s) next_seq_err = 1'b1;
      // [RULE3] apply on strobe fall
      if (strobe_fall) begin
        // [RULE4] [RULE25] only shifted low bits change
        next_cfg = (cfg & ~mask) | (shreg & mask);
        if (count != '0) next_valid = 1'b1;
      end
      unique case (state)
        TCL_OFF: begin
          if (power_up_request) begin
            next_state = TCL_SETTLE;
            next_settle = '0;
          end
        end
        TCL_SETTLE: begin
          // [RULE17] settle before config or active
          if (!power_up_request) begin
            // a dropped request restarts the wait from power down
            next_state = TCL_OFF;
          end else if (settle == TW'(SETTLE_CYC - 1)) begin
            next_state = TCL_STANDBY;
          end else begin
            next_settle = settle + 1'b1;
          end
          if (strobe_s || act_s) next_seq_err = 1'b1;
        end
        TCL_STANDBY: begin
          if (!power_up_request) begin
            next_state = TCL_OFF;
          end else if (strobe_s && !act_s) begin
            next_state = TCL_CONFIG;
          end else if (act_s && !strobe_s) begin
            // [RULE18] [RULE19] active only with a held word
            if (valid) next_state = TCL_ACTIVE;
            else next_seq_err = 1'b1;
          end
        end
        TCL_CONFIG: begin
          // word itself is applied by the strobe fall above
          if (!strobe_s) next_state = TCL_STANDBY;
        end
        TCL_ACTIVE: begin
          // [RULE22] activate fall starts burst send
          if (act_fall) begin
            if (cfg[`TCL_BIT_MODE]) begin
              next_state = TCL_SEND;
              next_tx_start = 1'b1;
            end else begin
              // direct mode has no send phase
              next_state = TCL_STANDBY;
            end
          end
        end
        TCL_SEND: begin
          // [RULE22] back to standby when done
          if (done_p[1]) next_state = TCL_STANDBY;
        end
      endcase
    end
  end

  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      state <= TCL_OFF;
      settle <= '0;
      // [RULE16] default word after reset
      cfg <= DEFAULT;
      valid <= 1'b0;
      tx_start <= 1'b0;
      seq_err <= 1'b0;
    end else begin
      state <= next_state;
      settle <= next_settle;
      cfg <= next_cfg;
      valid <= next_valid;
      tx_start <= next_tx_start;
      seq_err <= next_seq_err;
    end
  end

  tcl_fields_t f;
  always_comb begin
    // [RULE23] [RULE8] crc fields
    f.crc_len16 = cfg[`TCL_BIT_CRC_LEN];
    f.crc_en = cfg[`TCL_BIT_CRC_EN];
    // [RULE10] mode select
    f.burst_mode = cfg[`TCL_BIT_MODE];
    // [RULE11] data rate
    f.rate_1m = cfg[`TCL_BIT_RATE];
    // [RULE12] crystal field
    f.crystal_freq_select = cfg[`TCL_XO_MSB:`TCL_XO_LSB];
    // [RULE13] power field
    f.output_power_level = cfg[`TCL_PWR_MSB:`TCL_PWR_LSB];
    // [RULE14] channel field
    f.channel_number = cfg[`TCL_CH_MSB:`TCL_CH_LSB];
    // [RULE7] crc meaningless in direct mode
    if (!f.burst_mode) begin
      f.crc_en = 1'b0;
      f.crc_len16 = 1'b0;
    end
  end

  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      // fields reset to the decode of the default word so both agree
      // [RULE21] outputs forced to defaults
      CONFIG_WORD <= `TCL_CFG_DEFAULT;
      CONFIG_VALID <= 1'b0;
      CRC_ENABLE <= DEFAULT[`TCL_BIT_CRC_EN] & DEFAULT[`TCL_BIT_MODE];
      CRC_LEN16 <= DEFAULT[`TCL_BIT_CRC_LEN] & DEFAULT[`TCL_BIT_MODE];
      BURST_MODE <= DEFAULT[`TCL_BIT_MODE];
      RATE_1M <= DEFAULT[`TCL_BIT_RATE];
      CRYSTAL_FREQ_SELECT <= DEFAULT[`TCL_XO_MSB:`TCL_XO_LSB];
      OUTPUT_POWER_LEVEL <= DEFAULT[`TCL_PWR_MSB:`TCL_PWR_LSB];
      CHANNEL_NUMBER <= DEFAULT[`TCL_CH_MSB:`TCL_CH_LSB];
      CONFIG_MODE <= 1'b0;
      ACTIVE_MODE <= 1'b0;
      TX_START <= 1'b0;
      STANDBY <= 1'b0;
      SEQ_ERROR <= 1'b0;
    end else begin
      CONFIG_WORD <= cfg;
      CONFIG_VALID <= valid;
      CRC_ENABLE <= f.crc_en;
      CRC_LEN16 <= f.crc_len16;
      BURST_MODE <= f.burst_mode;
      RATE_1M <= f.rate_1m;
      CRYSTAL_FREQ_SELECT <= f.crystal_freq_select;
      OUTPUT_POWER_LEVEL <= f.output_power_level;
      CHANNEL_NUMBER <= f.channel_number;
      CONFIG_MODE <= (state == TCL_CONFIG);
      ACTIVE_MODE <= (state == TCL_ACTIVE) || (state == TCL_SEND);
      TX_START <= tx_start;
      STANDBY <= (state == TCL_STANDBY);
      SEQ_ERROR <= seq_err;
    end
  end
endmodule
`default_nettype wire

// ---- pkg/tcl_cfg.svh ----
// Behaviour
// [RULE1] one configuration register of up to 18 bits, shifted only while strobe high
// [RULE2] bits arrive msb first, sampled on rising shift clock edge
// [RULE3] shifted word applied only when strobe falls
// [RULE4] on strobe fall update only as many bits as were shifted
// [RULE5] host never shifts more than 18 bits per access
// [RULE6] host may later reload only bits 7 to 0
// [RULE7] direct mode: only bits 15 to 0 matter, crc bits ignored
// [RULE8] bits 17 and 16 hold crc setup, kept while supply present
// [RULE9] host writes bit 15 as zero
// [RULE10] bit 14 selects direct (0) or burst (1) mode
// [RULE11] bit 13 selects 250 kbps (0) or 1 Mbps (1)
// [RULE12] bits 12 to 10 give fitted crystal frequency
// [RULE13] bits 9 and 8 select transmit output power
// [RULE14] bits 7 to 1 give channel; frequency 2400 MHz plus channel MHz
// [RULE15] host writes bit 0 as zero
// [RULE16] register holds default 0x10F04 until loaded
// [RULE17] host waits 3 ms after power down before strobe or activate
// [RULE18] supply loss clears configuration; reconfigure before active mode
// [RULE19] with valid configuration, power down may go straight to active mode
// [RULE20] host never raises strobe and transmit-activate together
// [RULE21] in reset: strobe low, activate low, power-up high; the testbench holds power-up low until reset is released
// [RULE22] burst: activate high, clock in data, fall starts transmission, back to standby
// [RULE23] bit 17 picks crc length 8 or 16, bit 16 enables crc
// [RULE24] shift clock and data ignored while strobe low
// [RULE25] a load of N bits lands in the N low positions
`ifndef TCL_CFG_SVH
`define TCL_CFG_SVH
`define TCL_CFG_WIDTH 18
`define TCL_CFG_DEFAULT 18'h10F04
`define TCL_BIT_CRC_LEN 17
`define TCL_BIT_CRC_EN 16
`define TCL_BIT_MODE 14
`define TCL_BIT_RATE 13
`define TCL_XO_MSB 12
`define TCL_XO_LSB 10
`define TCL_PWR_MSB 9
`define TCL_PWR_LSB 8
`define TCL_CH_MSB 7
`define TCL_CH_LSB 1
`define TCL_SETTLE_US 3000
`define TCL_CLK_KHZ 10000
`define TCL_SETTLE_CYC ((`TCL_SETTLE_US * `TCL_CLK_KHZ + 999) / 1000)
`endif

// ---- pkg/tcl_pkg.sv ----
package tcl_pkg;
  typedef struct packed {
    logic crc_len16;
    logic crc_en;
    logic burst_mode;
    logic rate_1m;
    logic [2:0] crystal_freq_select;
    logic [1:0] output_power_level;
    logic [6:0] channel_number;
  } tcl_fields_t;
  typedef enum {TCL_OFF, TCL_SETTLE, TCL_STANDBY, TCL_CONFIG, TCL_ACTIVE, TCL_SEND}
    tcl_state_t;
endpackage

// ---- hdl/tcl_sync.sv ----
`timescale 1ns/1ns
`default_nettype none
module tcl_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] d,
  output var logic [W-1:0] q
);
  logic [W-1:0] meta;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta <= '0;
      q <= '0;
    end else begin
      meta <= d;
      q <= meta;
    end
  end
endmodule
`default_nettype wire

// ---- hdl/tcl_shifter.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "tcl_cfg.svh"
module tcl_shifter
  import tcl_pkg::*;
#(
  parameter int W = `TCL_CFG_WIDTH
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic strobe,
  input wire logic shift_rise,
  input wire logic data,
  output var logic [W-1:0] shreg,
  output var logic [$clog2(W+1)-1:0] count
);
  logic [W-1:0] next_shreg;
  logic [$clog2(W+1)-1:0] next_count;
  if (W < 8) begin : g_bad_width
    $error("width too small");
  end
  always_comb begin
    next_shreg = shreg;
    next_count = count;
    if (!strobe) begin
      // [RULE24] idle while strobe low
      next_count = '0;
    end else if (shift_rise) begin
      // [RULE2] msb first, rising edge
      next_shreg = {shreg[W-2:0], data};
      // [RULE1] counts saturate at width
      if (count != W[$clog2(W+1)-1:0]) next_count = count + 1'b1;
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      shreg <= '0;
      count <= '0;
    end else begin
      shreg <= next_shreg;
      count <= next_count;
    end
  end
endmodule
`default_nettype wire

// ---- verification/tcl_props.sv ----
`timescale 1ns/1ns
`default_nettype none
module tcl_props #(
  parameter int W = 18
) (
  input wire logic CORE_CLK,
  input wire logic RST_N,
  input wire logic SUPPLY_OK,
  input wire logic STROBE,
  input wire logic [W-1:0] CONFIG_WORD,
  input wire logic CONFIG_VALID,
  input wire logic CRC_ENABLE,
  input wire logic BURST_MODE,
  input wire logic [1:0] OUTPUT_POWER_LEVEL,
  input wire logic [6:0] CHANNEL_NUMBER,
  input wire logic CONFIG_MODE,
  input wire logic ACTIVE_MODE,
  input wire logic TX_START,
  input wire logic SEQ_ERROR
);
  default clocking cb @(posedge CORE_CLK);
  endclocking
  default disable iff (!RST_N);
  // long enough to cover the synchroniser and apply delay
  sequence strobe_held;
    (STROBE && SUPPLY_OK)[*6];
  endsequence
  sequence strobe_idle;
    (!STROBE && SUPPLY_OK)[*8];
  endsequence
  sequence supply_gone;
    (!SUPPLY_OK)[*6];
  endsequence
  word_hold_a: assert property (strobe_held |-> $stable(CONFIG_WORD))
    else $error("word changed while strobe high");
  idle_ignore_a: assert property (strobe_idle |-> $stable(CONFIG_WORD))
    else $error("word changed while strobe low");
  field_map_a: assert property ({BURST_MODE, OUTPUT_POWER_LEVEL, CHANNEL_NUMBER} ==
    {CONFIG_WORD[14], CONFIG_WORD[9:1]}) else $error("field outputs disagree with word");
  crc_mask_a: assert property (CRC_ENABLE == (CONFIG_WORD[14] && CONFIG_WORD[16]))
    else $error("crc enable wrong for mode");
  supply_clear_a: assert property (supply_gone |->
    CONFIG_WORD == 18'h10F04 && !CONFIG_VALID) else $error("word kept after supply loss");
  err_sticky_a: assert property (SEQ_ERROR |=> SEQ_ERROR)
    else $error("sequence error cleared");
  mode_excl_a: assert property (!(CONFIG_MODE && ACTIVE_MODE))
    else $error("config and active together");
  active_valid_a: assert property (ACTIVE_MODE |-> CONFIG_VALID)
    else $error("active without valid word");
  start_pulse_a: assert property (TX_START |=> !TX_START && BURST_MODE)
    else $error("start pulse too long");
endmodule
bind tcl_loader tcl_props #(.W(W)) u_props (
  .CORE_CLK(CORE_CLK), .RST_N(RST_N), .SUPPLY_OK(SUPPLY_OK), .STROBE(STROBE),
  .CONFIG_WORD(CONFIG_WORD), .CONFIG_VALID(CONFIG_VALID), .CRC_ENABLE(CRC_ENABLE),
  .BURST_MODE(BURST_MODE), .OUTPUT_POWER_LEVEL(OUTPUT_POWER_LEVEL),
  .CHANNEL_NUMBER(CHANNEL_NUMBER), .CONFIG_MODE(CONFIG_MODE), .ACTIVE_MODE(ACTIVE_MODE),
  .TX_START(TX_START), .SEQ_ERROR(SEQ_ERROR)
);
`default_nettype wire

// ---- verification/tcl_host.sv ----
`timescale 1ns/1ns
`default_nettype none
module tcl_host (
  output var logic strobe,
  output var logic sclk,
  output var logic data
);
  initial begin
    strobe = 1'b0;
    sclk = 1'b0;
    data = 1'b0;
  end
  task automatic load(input logic [17:0] w, input int n);
    if (n > 18) n = 18;
    strobe = 1'b1;
    #400;
    for (int i = n - 1; i >= 0; i--) begin
      data = w[i];
      #400 sclk = 1'b1;
      #400 sclk = 1'b0;
    end
    // released line must not show a stale bit
    data = ~data;
    #400 strobe = 1'b0;
  endtask
  task automatic wiggle(input int k);
    repeat (k) begin
      data = ~data;
      #400 sclk = 1'b1;
      #400 sclk = 1'b0;
    end
  endtask
endmodule
`default_nettype wire

// ---- verification/test_tx_config_word_loader.sv ----
`timescale 1ns/1ns
`default_nettype none
module test_tx_config_word_loader import tcl_pkg::*;;
  logic clk = 1'b0, rst_n = 1'b0, sup = 1'b1, act = 1'b0, pu = 1'b0, done = 1'b0;
  logic strobe, sclk, sdata, valid, crc_en, crc16, burst, rate_1m, act_m, tx_start, stby, err;
  logic cfg_m;
  logic [17:0] word;
  logic [2:0] xo;
  logic [1:0] pwr;
  logic [6:0] ch;
  logic [17:0] exp_w = 18'h10F04;
  logic exp_v = 1'b0;
  int n_mismatch = 0, checks = 0, r;
  int lens[8] = '{18, 8, 0, 1, 17, 18, 7, 16};
  tcl_fields_t f;
  always #50 clk = ~clk;
  tcl_host host (.strobe(strobe), .sclk(sclk), .data(sdata));
  tcl_loader #(.SETTLE_CYC(20)) dut (.CORE_CLK(clk), .RST_N(rst_n), .SUPPLY_OK(sup),
    .STROBE(strobe), .TX_ACTIVATE(act), .POWER_UP_REQUEST(pu), .CONFIG_SHIFT_CLOCK(sclk),
    .CONFIG_DATA(sdata), .TX_DONE(done), .CONFIG_WORD(word), .CONFIG_VALID(valid),
    .CRC_ENABLE(crc_en), .CRC_LEN16(crc16), .BURST_MODE(burst), .RATE_1M(rate_1m),
    .CRYSTAL_FREQ_SELECT(xo), .OUTPUT_POWER_LEVEL(pwr), .CHANNEL_NUMBER(ch),
    .CONFIG_MODE(cfg_m), .ACTIVE_MODE(act_m), .TX_START(tx_start), .STANDBY(stby),
    .SEQ_ERROR(err));
  task automatic chk(input logic [17:0] got, input logic [17:0] want);
    checks++;
    if (got !== want) begin
      n_mismatch++;
      $display("mismatch at %0t: got %h expected %h", $time, got, want);
    end
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic wait_for(ref logic s);
    repeat (80) if (s !== 1'b1) @(negedge clk);
    if (s !== 1'b1) n_mismatch++;
  endtask
  task automatic chk_all;
    f = {exp_w[17:16], exp_w[14:1]};
    // crc settings only count in burst mode
    f.crc_en = f.crc_en & f.burst_mode;
    f.crc_len16 = f.crc_len16 & f.burst_mode;
    chk(word, exp_w);
    chk(18'(valid), 18'(exp_v));
    chk(18'({crc16, crc_en, burst, rate_1m, xo, pwr, ch}), 18'(f));
  endtask
  task automatic load(input logic [17:0] w, input int n);
    logic [17:0] m;
    m = (18'h1 << n) - 18'h1;
    // strobe high in standby must show config mode, not standby
    fork
      host.load(w, n);
      begin
        repeat (6) @(negedge clk);
        chk(18'({cfg_m, stby}), 18'h2);
      end
    join
    exp_w = (exp_w & ~m) | (w & m);
    exp_v = exp_v | (n > 0);
    repeat (8) @(negedge clk);
    chk_all();
  endtask
  initial begin
    #2000000;
    n_mismatch++;
    summarize();
  end
  initial begin
    r = $urandom(79039);
    repeat (10) @(negedge clk);
    rst_n = 1'b1;
    chk(word, 18'h10F04);
    chk(18'(valid), 18'h0);
    chk_all();
    pu = 1'b1;
    wait_for(stby);
    chk(18'(stby), 18'h1);
    foreach (lens[i]) begin
      load(18'($urandom) & 18'h37FFE, lens[i]);
      host.wiggle(3);
      repeat (8) @(negedge clk);
      chk(word, exp_w);
    end
    load(18'h34F0A, 18);
    pu = 1'b0;
    repeat (6) @(negedge clk);
    pu = 1'b1;
    wait_for(stby);
    act = 1'b1;
    repeat (8) @(negedge clk);
    chk(18'(act_m), 18'h1);
    act = 1'b0;
    wait_for(tx_start);
    chk(18'(tx_start), 18'h1);
    done = 1'b1;
    @(negedge clk);
    done = 1'b0;
    wait_for(stby);
    chk(18'(stby), 18'h1);
    chk(18'(err), 18'h0);
    sup = 1'b0;
    repeat (10) @(negedge clk);
    exp_w = 18'h10F04;
    exp_v = 1'b0;
    chk(word, 18'h10F04);
    chk(18'(valid), 18'h0);
    chk_all();
    sup = 1'b1;
    wait_for(stby);
    act = 1'b1;
    repeat (8) @(negedge clk);
    chk(18'({act_m, err}), 18'h1);
    act = 1'b0;
    summarize();
  end
endmodule
`default_nettype wire
